// ==== core/bcsr_pkg.sv ====
// Constants and carrier types for the bridge control/status register bank.
// Assumes an 8-bit system bus with 16-bit byte addresses, clocked by the core clock.
package bcsr_pkg;

  // Register byte addresses
  localparam logic [15:0] BCSR_ADDR_ID        = 16'h8000;
  localparam logic [15:0] BCSR_ADDR_PARITY    = 16'h8001;
  localparam logic [15:0] BCSR_ADDR_FLAGS     = 16'h8002;
  localparam logic [15:0] BCSR_ADDR_SLOT_BASE = 16'h8003;
  localparam int          BCSR_NUM_SLOTS      = 8;

  // Field positions in the parity type select register
  localparam int          BCSR_TX_ODD_BIT     = 0;
  localparam int          BCSR_RX_ODD_BIT     = 1;

  // Values after reset
  localparam logic [7:0]  BCSR_PARITY_RST     = 8'h03;
  localparam logic [7:0]  BCSR_ID_DEFAULT     = 8'h5a;  // Arbitrary value, set per build
  localparam logic [7:0]  BCSR_RDATA_RST      = 8'h00;

  // One bus request per cycle: single-byte read or write
  typedef struct packed {
    logic [15:0] addr;
    logic        wr;
    logic        rd;
    logic [7:0]  wdata;
  } bcsr_bus_req_t;

  // One received SPI-3 data word with its parity bit
  typedef struct packed {
    logic        vld;
    logic [31:0] data;
    logic        par;
  } bcsr_rx_word_t;

endpackage

// ==== core/bcsr_regs.sv ====
// Control/status register bank of the SPI-3 to SPI-4 bridge, with parity
// checking/generation and the eight-slot read schedule it steers.
// Assumes bus requests and datapath words come from core logic in the mclk_i domain.
`timescale 1ns/10ps
module bcsr_regs
  import bcsr_pkg::*;
#(
  parameter int         NUM_IFACE = 4,   // SPI-3 interfaces, 1 to 4
  parameter int         NUM_PORTS = 4,   // Ports per interface
  parameter int         SLOT_W    = 3,   // Width of a slot FIFO choice
  parameter logic [7:0] ID_VALUE  = BCSR_ID_DEFAULT
) (
  input  wire logic                          mclk_i,
  input  wire logic                          rstn_i,
  input  wire logic                          ce_i,
  input  wire bcsr_bus_req_t                 bus_i,
  output logic          [7:0]                rdata_o,
  output logic                               rvalid_o,
  input  wire bcsr_rx_word_t [NUM_IFACE-1:0] rx_i,
  input  wire logic [NUM_IFACE-1:0][31:0]    tx_data_i,
  output logic          [NUM_IFACE-1:0]      tx_parity_bit_o,
  output logic                               transmit_odd_parity_sel_o,
  output logic                               receive_odd_parity_sel_o,
  output logic          [NUM_IFACE-1:0]      iface_parity_fault_flag_o,
  input  wire logic                          slot_adv_i,
  output logic          [2:0]                slot_idx_o,
  output logic          [SLOT_W-1:0]         slot_fifo_choice_o,
  output logic          [SLOT_W-1:0]         slot0_fifo_choice_o,
  output logic          [SLOT_W-1:0]         slot1_fifo_choice_o
);

  localparam int NUM_FIFOS = NUM_IFACE * NUM_PORTS;  // Virtual FIFOs in buffer memory

  // State
  logic [7:0]           parity_q;                   // Parity type select register
  logic [NUM_IFACE-1:0] flags_q;                    // Sticky parity fault flags
  logic [SLOT_W-1:0]    slot_q [BCSR_NUM_SLOTS];    // Read schedule
  logic [2:0]           slot_idx_q;                 // Current schedule slot
  logic [7:0]           rdata_q;                    // Registered read data
  logic                 rvalid_q;                   // Read answer strobe

  // Address decode, all single-byte
  wire logic        wr_en      = ce_i & bus_i.wr;
  wire logic        rd_en      = ce_i & bus_i.rd;
  wire logic [15:0] slot_off   = bus_i.addr - BCSR_ADDR_SLOT_BASE;
  wire logic        hit_parity = (bus_i.addr == BCSR_ADDR_PARITY);
  wire logic        hit_flags  = (bus_i.addr == BCSR_ADDR_FLAGS);
  wire logic        hit_id     = (bus_i.addr == BCSR_ADDR_ID);
  wire logic        hit_slot   = (bus_i.addr >= BCSR_ADDR_SLOT_BASE) &&
                                 (slot_off < 16'(BCSR_NUM_SLOTS));
  wire logic [2:0]  slot_sel   = slot_off[2:0];
  wire logic        rd_flags   = rd_en & hit_flags;

  // Parity selects drive the datapath
  assign transmit_odd_parity_sel_o = parity_q[BCSR_TX_ODD_BIT];
  assign receive_odd_parity_sel_o  = parity_q[BCSR_RX_ODD_BIT];

  // Per interface: check received parity, generate transmit parity
  logic [NUM_IFACE-1:0] par_err;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IFACE; gi++) begin : g_iface
      // Odd parity means data plus parity bit has an odd count of ones
      assign par_err[gi]  = rx_i[gi].vld &
        ((^{rx_i[gi].data, rx_i[gi].par}) != receive_odd_parity_sel_o);
      assign tx_parity_bit_o[gi] = (^tx_data_i[gi]) ^ transmit_odd_parity_sel_o;
    end
  endgenerate

  // Read mux; unmapped addresses read zero, identity never changes
  wire logic [7:0] rd_mux =
    hit_id     ? ID_VALUE :
    hit_parity ? parity_q :
    hit_flags  ? 8'(flags_q) :
    hit_slot   ? 8'(slot_q[slot_sel]) :
                 BCSR_RDATA_RST;

  // Parity select register, only D1..D0 are meaningful
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      parity_q <= BCSR_PARITY_RST;
    end else if (wr_en && hit_parity) begin
      parity_q <= {6'h00, bus_i.wdata[1:0]};
    end
  end

  // Fault flags: a fault in the reading cycle survives the clear
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flags_q <= '0;
    end else if (ce_i) begin
      flags_q <= (rd_flags ? '0 : flags_q) | par_err;
    end
  end
  assign iface_parity_fault_flag_o = flags_q;

  // Slot registers; reset spreads slots round the configured FIFOs
  generate
    for (gi = 0; gi < BCSR_NUM_SLOTS; gi++) begin : g_slot
      always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          slot_q[gi] <= SLOT_W'(gi % NUM_FIFOS);
        end else if (wr_en && hit_slot && (slot_sel == 3'(gi))) begin
          slot_q[gi] <= bus_i.wdata[SLOT_W-1:0];
        end
      end
    end
  endgenerate

  // Schedule walks slots 0..7 as the reader advances
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      slot_idx_q <= 3'h0;
    end else if (ce_i && slot_adv_i) begin
      slot_idx_q <= slot_idx_q + 3'h1;
    end
  end
  assign slot_idx_o          = slot_idx_q;
  assign slot_fifo_choice_o  = slot_q[slot_idx_q];
  assign slot0_fifo_choice_o = slot_q[0];
  assign slot1_fifo_choice_o = slot_q[1];

  // Read answer one cycle after the strobe, from flops
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_q  <= BCSR_RDATA_RST;
      rvalid_q <= 1'b0;
    end else if (ce_i) begin
      rvalid_q <= bus_i.rd;
      if (bus_i.rd) begin
        rdata_q <= rd_mux;
      end
    end
  end
  assign rdata_o  = rdata_q;
  assign rvalid_o = rvalid_q;

  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  logic par_wr_seen_q;  // Any write to parity select since reset
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      par_wr_seen_q <= 1'b0;
    end else if (wr_en && hit_parity) begin
      par_wr_seen_q <= 1'b1;
    end
  end

  property p_tx_sel;
    wr_en && hit_parity |=> transmit_odd_parity_sel_o == $past(bus_i.wdata[0]);
  endproperty
  a_tx_sel: assert property (p_tx_sel) else $error("tx parity select wrong");

  property p_rx_sel;
    wr_en && hit_parity |=> receive_odd_parity_sel_o == $past(bus_i.wdata[1]);
  endproperty
  a_rx_sel: assert property (p_rx_sel) else $error("rx parity select wrong");

  property p_par_rst;
    !par_wr_seen_q |-> parity_q == BCSR_PARITY_RST;
  endproperty
  a_par_rst: assert property (p_par_rst) else $error("parity reset value lost");

  property p_flag_hold;
    ce_i && flags_q[0] && !rd_flags |=> flags_q[0];
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped unread");

  property p_flag_clr;
    rd_flags && par_err == '0 |=> flags_q == '0 ##0 rvalid_o;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared on read");

  // Written choice lands in slot 0 and steers the reader while slot 0 is current
  property p_slot0;
    wr_en && bus_i.addr == BCSR_ADDR_SLOT_BASE
      |=> slot0_fifo_choice_o == $past(bus_i.wdata[SLOT_W-1:0]) &&
          (slot_idx_o != 3'h0 || slot_fifo_choice_o == $past(bus_i.wdata[SLOT_W-1:0]));
  endproperty
  a_slot0: assert property (p_slot0) else $error("slot 0 choice wrong");

  // Same for slot 1, one address above the base
  property p_slot1;
    wr_en && bus_i.addr == BCSR_ADDR_SLOT_BASE + 16'h1
      |=> slot1_fifo_choice_o == $past(bus_i.wdata[SLOT_W-1:0]) &&
          (slot_idx_o != 3'h1 || slot_fifo_choice_o == $past(bus_i.wdata[SLOT_W-1:0]));
  endproperty
  a_slot1: assert property (p_slot1) else $error("slot 1 choice wrong");

  property p_slot_rw;
    wr_en && bus_i.addr == BCSR_ADDR_SLOT_BASE + 16'h1 ##1
      rd_en && bus_i.addr == BCSR_ADDR_SLOT_BASE + 16'h1
      |=> rdata_o == 8'($past(bus_i.wdata[SLOT_W-1:0], 2));
  endproperty
  a_slot_rw: assert property (p_slot_rw) else $error("slot readback wrong");

  property p_rvalid;
    rd_en |=> rvalid_o ##1 (!$past(ce_i) || rvalid_o == $past(bus_i.rd));
  endproperty
  a_rvalid: assert property (p_rvalid) else $error("read answer missing");

  property p_sched;
    ce_i && slot_adv_i |=> slot_idx_o == $past(slot_idx_o) + 3'h1;
  endproperty
  a_sched: assert property (p_sched) else $error("schedule did not advance");

  property p_check;
    ce_i && par_err[0] |=> flags_q[0];
  endproperty
  a_check: assert property (p_check) else $error("parity fault not flagged");

  property p_id;
    rd_en && hit_id |=> rdata_o == ID_VALUE;
  endproperty
  a_id: assert property (p_id) else $error("identity value wrong");

  c_flag_set_clr: cover property (par_err[0] && ce_i ##[1:20] rd_flags);
  c_race:         cover property (rd_flags && par_err != '0);
  c_wrap:         cover property (slot_idx_o == 3'h7 && slot_adv_i && ce_i);
  c_par_even:     cover property (wr_en && hit_parity && bus_i.wdata[1:0] == 2'h0);

endmodule

// ==== testbench/bcsr_regs_test.sv ====
// Self-checking bench for the bridge control/status register bank.
// Assumes core/bcsr_pkg.sv and core/bcsr_regs.sv, one 20 MHz core clock.
`timescale 1ns/10ps
module bcsr_regs_test
  import bcsr_pkg::*;
;
  logic                   mclk_i;      // Core clock
  logic                   rstn_i;      // Async reset, active low
  logic                   ce_i;        // Clock enable
  logic                   slot_adv_i;  // Schedule advance
  bcsr_bus_req_t          bus;         // Register bus request
  bcsr_rx_word_t [3:0]    rx;          // Received words
  logic [3:0][31:0]       tx_data;     // Transmit words
  logic [7:0]             rdata;       // Read data
  logic                   rvalid;      // Read answer strobe
  logic [3:0]             tx_pbit;     // Generated parity bits
  logic [3:0]             flags;       // Sticky fault flags
  logic                   tx_sel;      // Transmit odd select
  logic                   rx_sel;      // Receive odd select
  logic [2:0]             idx;         // Current slot
  logic [2:0]             ch;          // Choice of current slot
  logic [2:0]             ch0;         // Slot 0 contents
  logic [2:0]             ch1;         // Slot 1 contents
  int                     mismatches;  // Failed comparisons
  int                     n_checks;    // All comparisons

  bcsr_regs i_dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(ce_i), .bus_i(bus),
    .rdata_o(rdata), .rvalid_o(rvalid), .rx_i(rx), .tx_data_i(tx_data),
    .tx_parity_bit_o(tx_pbit),
    .transmit_odd_parity_sel_o(tx_sel), .receive_odd_parity_sel_o(rx_sel),
    .iface_parity_fault_flag_o(flags), .slot_adv_i(slot_adv_i), .slot_idx_o(idx),
    .slot_fifo_choice_o(ch), .slot0_fifo_choice_o(ch0), .slot1_fifo_choice_o(ch1));

  // Free-running core clock, 50 ns period
  always #25 mclk_i = ~mclk_i;

  // Verdict and end of run, shared by timeouts
  task final_report();
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Case-equality compare so unknowns never match
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Single-byte write, strobe held for one edge
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk_i) bus <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge mclk_i) bus.wr <= 1'b0;
  endtask

  // Single-byte read, answer awaited under a bound
  // Answer stands only one cycle after the taking edge, so look just after it
  task rd(input logic [15:0] a, output logic [7:0] d);
    int i;
    i = 0;
    @(posedge mclk_i) bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge mclk_i) bus.rd <= 1'b0;
    #1;
    while (rvalid !== 1'b1 && i < 4) begin
      @(posedge mclk_i) #1 i++;
    end
    d = rdata;
    if (rvalid !== 1'b1) begin
      mismatches++;
      final_report();
    end
  endtask

  // One word per interface, only interface n carries parity p
  task t_rx(input int n, input logic p);
    logic [7:0] d;
    @(posedge mclk_i);
    for (int i = 0; i < 4; i++) rx[i] <= '{vld: 1'b1, data: 32'h0, par: (i == n) ? p : ~p};
    @(posedge mclk_i) rx <= '0;
    @(posedge mclk_i) #1 chk({4'h0, flags}, 8'h01 << n);
    rd(BCSR_ADDR_FLAGS, d);
    chk(d, 8'h01 << n);
    rd(BCSR_ADDR_FLAGS, d);
    chk(d, 8'h00);
  endtask

  // Reset contents, odd mode, then even mode and read-only identity
  task t_parity();
    logic [7:0] d;
    rd(BCSR_ADDR_PARITY, d);
    chk(d, BCSR_PARITY_RST);
    chk({6'h00, rx_sel, tx_sel}, 8'h03);
    chk({7'h00, tx_pbit[0]}, 8'h00);
    t_rx(2, 1'b0);
    wr(BCSR_ADDR_PARITY, 8'hfc);
    rd(BCSR_ADDR_PARITY, d);
    chk(d, 8'h00);
    chk({6'h00, rx_sel, tx_sel}, 8'h00);
    chk({7'h00, tx_pbit[0]}, 8'h01);
    t_rx(0, 1'b1);
    wr(BCSR_ADDR_ID, 8'h00);
    rd(BCSR_ADDR_ID, d);
    chk(d, BCSR_ID_DEFAULT);
    rd(16'h8010, d);
    chk(d, 8'h00);
  endtask

  // Slot contents after reset, rewrite, and schedule stepping
  task t_slots();
    logic [7:0] d;
    rd(BCSR_ADDR_SLOT_BASE + 16'h1, d);
    chk(d, 8'h01);
    chk({5'h0, ch}, 8'h00);
    wr(BCSR_ADDR_SLOT_BASE, 8'hfd);
    wr(BCSR_ADDR_SLOT_BASE + 16'h1, 8'h06);
    rd(BCSR_ADDR_SLOT_BASE, d);
    chk(d, 8'h05);
    chk({5'h0, ch0}, 8'h05);
    chk({5'h0, ch1}, 8'h06);
    chk({5'h0, ch}, 8'h05);
    @(posedge mclk_i) slot_adv_i <= 1'b1;
    @(posedge mclk_i) slot_adv_i <= 1'b0;
    #1 chk({5'h0, idx}, 8'h01);
    chk({5'h0, ch}, 8'h06);
  endtask

  // Clock enable low: a bus write and a schedule step are both ignored
  task t_hold();
    @(posedge mclk_i) ce_i <= 1'b0;
    wr(BCSR_ADDR_SLOT_BASE, 8'h02);
    @(posedge mclk_i) slot_adv_i <= 1'b1;
    @(posedge mclk_i) slot_adv_i <= 1'b0;
    ce_i <= 1'b1;
    #1 chk({5'h0, ch0}, 8'h05);
    chk({5'h0, idx}, 8'h01);
  endtask

  // Main sequence: reset for 20 cycles, then each scenario
  initial begin
    mclk_i = 1'b0;
    rstn_i = 1'b0;
    ce_i = 1'b1;
    slot_adv_i = 1'b0;
    bus = '0;
    rx = '0;
    tx_data = {32'h0, 32'h0, 32'h0, 32'h1};
    mismatches = 0;
    n_checks = 0;
    repeat (20) @(posedge mclk_i);
    rstn_i <= 1'b1;
    t_parity();
    t_slots();
    t_hold();
    final_report();
  end
endmodule
